// >>> pkg/complex_logic_array_omc_pkg.sv
// Shared constants and carrier types for the output logic cell array.
// Assumes one 100 MHz clock domain and a host that reaches the array
// through the configuration/IO block select of the parallel bus.
package complex_logic_array_omc_pkg;

  // ----------------------------------------------------------------
  // Array shape
  // ----------------------------------------------------------------
  localparam int CELLS = 16;
  localparam int GROUP = 8;
  localparam int TERMS = 4;
  localparam int FIRST_BC = 8;
  localparam int BC_HIGH_FIRST = 12;
  localparam int AB_NATIVE = 3;
  localparam int BC_NATIVE = 4;
  localparam int AB_BORROW = 6;
  localparam int BC_LOW_BORROW = 5;
  localparam int BC_HIGH_BORROW = 6;

  // ----------------------------------------------------------------
  // Register offsets inside the configuration/IO block, reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_AB_FLOPS = 8'h20;
  localparam logic [7:0] OFS_BC_FLOPS = 8'h21;
  localparam logic [7:0] OFS_AB_MASK = 8'h22;
  localparam logic [7:0] OFS_BC_MASK = 8'h23;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FLOPS_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FF_D = 2'b00,
    FF_T = 2'b01,
    FF_JK = 2'b10,
    FF_SR = 2'b11
  } flop_kind_t;

  typedef enum logic [1:0] {
    PIN_AUTO = 2'b00,
    PIN_FIRST = 2'b01,
    PIN_SECOND = 2'b10,
    PIN_NODE = 2'b11
  } pin_route_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic invert;
    logic registered;
    flop_kind_t kind;
    logic ext_clock;
    pin_route_t route;
    logic oe_equation;
    logic [TERMS-1:0] use_native;
    logic [TERMS-1:0] borrow_left;
    logic [TERMS-1:0] borrow_right;
    logic expand_on;
    logic [3:0] expand_src;
  } cell_cfg_t;

  typedef struct packed {
    logic [TERMS-1:0] native;
    logic k;
    logic clock;
    logic preset;
    logic [1:0] clear;
    logic oe;
  } cell_terms_t;

  typedef struct packed {
    logic select;
    logic wr_n;
    logic rd_n;
    logic [7:0] addr;
    logic [7:0] data;
  } host_bus_t;

  typedef struct packed {
    logic [7:0] a_out;
    logic [7:0] a_oe;
    logic [7:0] b_out;
    logic [7:0] b_oe;
    logic [7:0] c_out;
    logic [7:0] c_oe;
  } port_pins_t;

endpackage : complex_logic_array_omc_pkg

// >>> verilog/output_logic_cell.sv
// One output logic cell: term sum, polarity, flip-flop next state, and
// the registered/combinatorial output selection.
// Assumes the caller holds the flip-flop and decides borrowing.
`timescale 1ns/1ps
module output_logic_cell
  import complex_logic_array_omc_pkg::*;
#(
  parameter int NATIVE = AB_NATIVE
) (
  // Configuration and terms
  input wire cell_cfg_t cfg,
  input wire cell_terms_t terms,
  input wire logic borrowed_or,
  input wire logic expand_val,
  // Flip-flop context
  input wire logic q,
  input wire logic clk_fire,
  input wire logic load_en,
  input wire logic load_bit,
  // Results
  output logic sum_raw,
  output logic next_q,
  output logic cell_out
);

  // ----------------------------------------------------------------
  // Term sum and polarity
  // ----------------------------------------------------------------
  logic [TERMS-1:0] native_mask;
  logic logic_val;
  logic cleared;

  // Terms above the native count do not exist in this cell.
  always_comb begin
    native_mask = '0;
    for (int t = 0; t < NATIVE; t++) begin
      native_mask[t] = 1'b1;
    end
    sum_raw = |(terms.native & cfg.use_native & native_mask) | borrowed_or
      | expand_val;
    logic_val = sum_raw ^ cfg.invert;
    cleared = |terms.clear;
  end

  // ----------------------------------------------------------------
  // Flip-flop next state
  // ----------------------------------------------------------------
  // Preset and clear act whenever high; clear wins because a stuck
  // preset must not block a reset of the machine. A host load beats both.
  always_comb begin
    next_q = q;
    if (clk_fire) begin
      case (cfg.kind)
        FF_D: next_q = logic_val;
        FF_T: next_q = q ^ logic_val;
        FF_JK: next_q = (logic_val & ~q) | (~terms.k & q);
        FF_SR: next_q = logic_val | (~terms.k & q);
        default: next_q = q;
      endcase
    end
    if (terms.preset) begin
      next_q = 1'b1;
    end
    if (cleared) begin
      next_q = 1'b0;
    end
    if (load_en) begin
      next_q = load_bit;
    end
  end

  // Output mux feeding both the pin and the array feedback.
  always_comb begin
    cell_out = cfg.registered ? q : logic_val;
  end

endmodule : output_logic_cell

// >>> verilog/complex_logic_array_output_cell_array.sv
// Sixteen output logic cells in two groups of eight, with host load,
// read back, load masks, term borrowing, expansion and pin routing.
// Assumes all inputs are synchronous to clk and the AND array, port
// direction registers and configuration bits come from outside.
//
// Notes on behaviour
// - Sixteen cells in two groups: AB drives ports A/B, BC ports B/C.
// - An unassigned cell output is routed to a port its group serves.
// - The summed terms pass an XOR that sets the result polarity.
// - A mux picks flop or logic result for pin and array feedback.
// - Each flop can act as D, toggle, JK or set-reset element.
// - Flop clocks from a product term or external pin rising edge.
// - Preset and clear are active-high terms; clear takes two terms.
// - AB: 3 native, 6 borrowed; BC0-3: 4 plus 5; BC4-7: 4 plus 6.
// - Borrow only from neighbours; a used term is never shared.
// - Expansion consumes another cell and adds a cycle of delay.
// - Cell n of each group maps to data bit n for loads and reads.
// - A host load overrides preset, clear and clock of the flop.
// - Each group sits in the config/IO block for load and read back.
// - Loads happen on write strobe trailing edge or while it is low.
// - One 8-bit mask per group, resetting to zero, allowing loads.
// - A set mask bit keeps that flop; unmasked bits still load.
// - Pin enable is the enable term ORed with the direction bit.
// - An output without enable equation drives from power-up on.
// - An internal node frees its pin but keeps feedback to the array.
`timescale 1ns/1ps
module complex_logic_array_output_cell_array
  import complex_logic_array_omc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Host parallel bus
  input wire host_bus_t host,
  output logic [7:0] host_rd_data,
  output logic host_rd_oe,
  // Configuration
  input wire logic edge_loading,
  input wire cell_cfg_t [CELLS-1:0] cfg,
  // AND array terms and external clock pin
  input wire cell_terms_t [CELLS-1:0] terms,
  input wire logic external_flop_clock_pin,
  // Port direction register bits
  input wire logic [7:0] dir_a,
  input wire logic [7:0] dir_b,
  input wire logic [7:0] dir_c,
  // Pins and feedback
  output port_pins_t pins,
  output logic [7:0] group_ab_feedback,
  output logic [7:0] group_bc_feedback
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic int native_count(input int i);
    return (i < FIRST_BC) ? AB_NATIVE : BC_NATIVE;
  endfunction : native_count

  function automatic int borrow_limit(input int i);
    if (i < FIRST_BC) begin
      return AB_BORROW;
    end
    return (i < BC_HIGH_FIRST) ? BC_LOW_BORROW : BC_HIGH_BORROW;
  endfunction : borrow_limit

  // Keeps only the first 'limit' set bits, so no cell exceeds its cap.
  function automatic logic [7:0] cap_bits(input logic [7:0] m,
                                          input int limit);
    logic [7:0] r;
    int n;
    r = '0;
    n = 0;
    for (int b = 0; b < 8; b++) begin
      if (m[b] && n < limit) begin
        r[b] = 1'b1;
        n++;
      end
    end
    return r;
  endfunction : cap_bits

  function automatic logic hit(input host_bus_t h, input logic [7:0] ofs);
    return h.select && (h.addr == ofs);
  endfunction : hit

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CELLS-1:0] flops;
    logic [7:0] mask_ab;
    logic [7:0] mask_bc;
    logic prev_wr_n;
    logic [7:0] wr_data;
    logic [3:0] wr_hits;
    logic [CELLS-1:0] prev_clk_term;
    logic prev_ext_clk;
    logic [CELLS-1:0] expand_reg;
    logic [7:0] rd_data;
    port_pins_t pins;
    logic [CELLS-1:0] feedback;
  } state_t;

  state_t st;
  state_t next_st;

  logic [CELLS-1:0] borrowed_or;
  logic [CELLS-1:0] expand_val;
  logic [CELLS-1:0] clk_fire;
  logic [CELLS-1:0] load_en;
  logic [CELLS-1:0] load_bit;
  logic [CELLS-1:0] sum_raw;
  logic [CELLS-1:0] next_q;
  logic [CELLS-1:0] cell_out;
  logic [CELLS-1:0] consumed;
  logic [3:0] now_hits;
  logic do_load;
  logic [7:0] load_data;
  logic [3:0] load_hits;

  // ----------------------------------------------------------------
  // Term borrowing between neighbours
  // ----------------------------------------------------------------
  // A right-hand request from the lower cell wins over a left-hand
  // request from the upper cell for the same term; terms the owner
  // uses are never lent. Neighbours never cross the group boundary.
  always_comb begin
    logic [7:0] req;
    logic [7:0] grant;
    int l;
    int r;
    int ll;
    req = '0;
    grant = '0;
    l = 0;
    r = 0;
    ll = 0;
    for (int i = 0; i < CELLS; i++) begin
      l = (i + CELLS - 1) % CELLS;
      r = (i + 1) % CELLS;
      ll = (i + CELLS - 2) % CELLS;
      req = '0;
      for (int t = 0; t < TERMS; t++) begin
        if ((i % GROUP) != GROUP - 1 && t < native_count(r)) begin
          req[t] = cfg[i].borrow_right[t] & ~cfg[r].use_native[t];
        end
        if ((i % GROUP) != 0 && t < native_count(l)) begin
          req[TERMS+t] = cfg[i].borrow_left[t] & ~cfg[l].use_native[t]
            & ~((i % GROUP) >= 2 && cfg[ll].borrow_right[t]);
        end
      end
      grant = cap_bits(req, borrow_limit(i));
      borrowed_or[i] = |(grant & {terms[l].native, terms[r].native});
    end
  end

  // ----------------------------------------------------------------
  // Expansion and clock selection
  // ----------------------------------------------------------------
  // Expansion goes through a register: it frees routing at the cost of
  // one extra cycle on the equation that needs it.
  always_comb begin
    consumed = '0;
    for (int i = 0; i < CELLS; i++) begin
      expand_val[i] = cfg[i].expand_on & st.expand_reg[cfg[i].expand_src];
      if (cfg[i].expand_on) begin
        consumed[cfg[i].expand_src] = 1'b1;
      end
      clk_fire[i] = cfg[i].ext_clock
        ? (external_flop_clock_pin & ~st.prev_ext_clk)
        : (terms[i].clock & ~st.prev_clk_term[i]);
    end
  end

  // ----------------------------------------------------------------
  // Host write capture and load
  // ----------------------------------------------------------------
  // In edge mode the data seen during the strobe is held and applied
  // when the strobe rises; level mode applies it every strobe cycle.
  always_comb begin
    now_hits = {hit(host, OFS_BC_MASK), hit(host, OFS_AB_MASK),
                hit(host, OFS_BC_FLOPS), hit(host, OFS_AB_FLOPS)};
    if (edge_loading) begin
      do_load = host.wr_n & ~st.prev_wr_n;
      load_data = st.wr_data;
      load_hits = st.wr_hits;
    end else begin
      do_load = ~host.wr_n;
      load_data = host.data;
      load_hits = now_hits;
    end
    for (int i = 0; i < CELLS; i++) begin
      if (i < FIRST_BC) begin
        load_en[i] = do_load & load_hits[0] & ~st.mask_ab[i];
      end else begin
        load_en[i] = do_load & load_hits[1]
          & ~st.mask_bc[i-FIRST_BC];
      end
      load_bit[i] = load_data[i % GROUP];
    end
  end

  // ----------------------------------------------------------------
  // Cell instances
  // ----------------------------------------------------------------
  for (genvar g = 0; g < CELLS; g++) begin : g_cell
    output_logic_cell #(
      .NATIVE(g < FIRST_BC ? AB_NATIVE : BC_NATIVE)
    ) u_cell (
      .cfg(cfg[g]),
      .terms(terms[g]),
      .borrowed_or(borrowed_or[g]),
      .expand_val(expand_val[g]),
      .q(st.flops[g]),
      .clk_fire(clk_fire[g]),
      .load_en(load_en[g]),
      .load_bit(load_bit[g]),
      .sum_raw(sum_raw[g]),
      .next_q(next_q[g]),
      .cell_out(cell_out[g])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic ab_drive;
    logic bc_drive;
    logic bc_on_b;
    logic ab_oe;
    logic bc_oe;
    ab_drive = 1'b0;
    bc_drive = 1'b0;
    bc_on_b = 1'b0;
    ab_oe = 1'b0;
    bc_oe = 1'b0;
    next_st = st;
    next_st.flops = next_q;
    next_st.prev_wr_n = host.wr_n;
    next_st.prev_clk_term = '0;
    for (int i = 0; i < CELLS; i++) begin
      next_st.prev_clk_term[i] = terms[i].clock;
    end
    next_st.prev_ext_clk = external_flop_clock_pin;
    next_st.expand_reg = sum_raw;
    if (!host.wr_n) begin
      next_st.wr_data = host.data;
      next_st.wr_hits = now_hits;
    end
    if (do_load && load_hits[2]) begin
      next_st.mask_ab = load_data;
    end
    if (do_load && load_hits[3]) begin
      next_st.mask_bc = load_data;
    end
    // Read back shows flop state, never filtered by the mask.
    if (now_hits[0]) begin
      next_st.rd_data = st.flops[GROUP-1:0];
    end else if (now_hits[1]) begin
      next_st.rd_data = st.flops[CELLS-1:FIRST_BC];
    end else if (now_hits[2]) begin
      next_st.rd_data = st.mask_ab;
    end else begin
      next_st.rd_data = st.mask_bc;
    end
    // Pin routing: AB defaults to port A, BC to port C, so automatic
    // placement never fights over port B. AB wins a port B clash unless its pin enable is low.
    next_st.pins = '0;
    for (int n = 0; n < GROUP; n++) begin
      ab_drive = (cfg[n].route != PIN_NODE) & ~consumed[n];
      bc_drive = (cfg[n+FIRST_BC].route != PIN_NODE)
        & ~consumed[n+FIRST_BC];
      bc_on_b = cfg[n+FIRST_BC].route == PIN_FIRST;
      ab_oe = ~cfg[n].oe_equation | terms[n].oe;
      bc_oe = ~cfg[n+FIRST_BC].oe_equation | terms[n+FIRST_BC].oe;
      if (ab_drive && cfg[n].route == PIN_SECOND) begin
        next_st.pins.b_out[n] = cell_out[n];
        next_st.pins.b_oe[n] = ab_oe | dir_b[n];
      end else if (ab_drive) begin
        next_st.pins.a_out[n] = cell_out[n];
        next_st.pins.a_oe[n] = ab_oe | dir_a[n];
      end
      if (bc_drive && bc_on_b && !next_st.pins.b_oe[n]) begin
        next_st.pins.b_out[n] = cell_out[n+FIRST_BC];
        next_st.pins.b_oe[n] = bc_oe | dir_b[n];
      end else if (bc_drive && !bc_on_b) begin
        next_st.pins.c_out[n] = cell_out[n+FIRST_BC];
        next_st.pins.c_oe[n] = bc_oe | dir_c[n];
      end
    end
    next_st.feedback = cell_out;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
      st.flops <= {FLOPS_RESET, FLOPS_RESET};
      st.mask_ab <= MASK_RESET;
      st.mask_bc <= MASK_RESET;
      st.prev_wr_n <= 1'b1;
      st.wr_hits <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign host_rd_data = st.rd_data;
  assign host_rd_oe = ~host.rd_n & (|now_hits);
  assign pins = st.pins;
  assign group_ab_feedback = st.feedback[GROUP-1:0];
  assign group_bc_feedback = st.feedback[CELLS-1:FIRST_BC];

endmodule : complex_logic_array_output_cell_array

// >>> verification/cell_array_properties.sv
// Concurrent checks on the host side and pins of the output cell array.
// Assumes it is bound to the array's top module and sees only its ports.
`timescale 1ns/1ps
module cell_array_checks
  import complex_logic_array_omc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Host side
  input wire logic ce,
  input wire host_bus_t host,
  input wire logic [7:0] host_rd_data,
  input wire logic host_rd_oe,
  input wire logic edge_loading,
  // Cell side
  input wire cell_cfg_t [CELLS-1:0] cfg,
  input wire cell_terms_t [CELLS-1:0] terms,
  input wire logic [7:0] dir_a,
  input wire port_pins_t pins,
  input wire logic [7:0] group_ab_feedback
);
  // ------
  // Helpers
  // ------
  logic hit;
  logic no_exp;
  logic ab_plain;

  // Readback equals feedback for registered cells; ab_plain also excludes inverted ones.
  always_comb begin
    hit = host.select && host.addr >= OFS_AB_FLOPS;
    hit = hit && host.addr <= OFS_BC_MASK;
    no_exp = 1'b1;
    ab_plain = 1'b1;
    for (int i = 0; i < CELLS; i++) begin
      if (cfg[i].expand_on) no_exp = 1'b0;
      if (i < GROUP && (!cfg[i].registered || cfg[i].invert)) ab_plain = 1'b0;
    end
    ab_plain = ab_plain && no_exp;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ------
  // Properties
  // ------
  property p_rd_oe;
    hit && !host.rd_n |-> host_rd_oe;
  endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("read enable missing");

  property p_rd_off;
    !(hit && !host.rd_n) |-> !host_rd_oe;
  endproperty
  a_rd_off: assert property (p_rd_off) else $error("stray read enable");

  property p_readback;
    ce && ab_plain && $stable(cfg) && host.select
      && host.addr == OFS_AB_FLOPS |=> host_rd_data == group_ab_feedback;
  endproperty
  a_readback: assert property (p_readback) else $error("readback wrong");

  property p_level;
    (!edge_loading && ce && host.select && !host.wr_n
      && host.addr == OFS_AB_MASK) ##1 (host.select
      && host.addr == OFS_AB_MASK) |=> host_rd_data == $past(host.data, 2);
  endproperty
  a_level: assert property (p_level) else $error("level load lost");

  property p_edge;
    (edge_loading && ce && host.select && !host.wr_n
      && host.addr == OFS_BC_MASK) ##1 (host.select && host.wr_n)
      ##1 (host.select && host.addr == OFS_BC_MASK)
      |=> host_rd_data == $past(host.data, 3);
  endproperty
  a_edge: assert property (p_edge) else $error("edge load lost");

  property p_node;
    (cfg[0].route == PIN_NODE) [*2] |-> !pins.a_oe[0];
  endproperty
  a_node: assert property (p_node) else $error("node pin driven");

  property p_oe_default;
    (cfg[0].route == PIN_FIRST && !cfg[0].oe_equation && no_exp) [*2]
      |-> pins.a_oe[0];
  endproperty
  a_oe_default: assert property (p_oe_default) else $error("pin off");

  property p_oe_or;
    cfg[0].route == PIN_FIRST && cfg[0].oe_equation && no_exp
      |=> pins.a_oe[0] == $past(terms[0].oe | dir_a[0]);
  endproperty
  a_oe_or: assert property (p_oe_or) else $error("pin enable wrong");
endmodule : cell_array_checks

// >>> verification/host_mcu_model.sv
// Host microcontroller model on the parallel bus of the cell array.
// Assumes its caller is one sequential process, driving 1 ns after edges.
`timescale 1ns/1ps
module host_mcu_model
  import complex_logic_array_omc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Parallel bus
  output host_bus_t host,
  input wire logic [7:0] host_rd_data,
  input wire logic host_rd_oe
);
  // Idle address and data lines show the inverse of their last value, never a stale copy.
  task automatic release_bus();
    host.select = 1'b0;
    host.wr_n = 1'b1;
    host.rd_n = 1'b1;
    host.addr = ~host.addr;
    host.data = ~host.data;
  endtask : release_bus

  // Strobe low two cycles, high two with the block still selected.
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d,
                           output logic [7:0] echo);
    @(posedge clk);
    #1 host.select = 1'b1;
    host.addr = a;
    host.data = d;
    host.wr_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 host.wr_n = 1'b1;
    @(posedge clk);
    #1 echo = host_rd_data;
    @(posedge clk);
    #1 release_bus();
  endtask : bus_write

  // One read cycle; the byte is taken once the sampling edge has landed.
  task automatic bus_read(input logic [7:0] a, output logic [7:0] d,
                          output logic oe);
    @(posedge clk);
    #1 host.select = 1'b1;
    host.addr = a;
    host.rd_n = 1'b0;
    #1 oe = host_rd_oe;
    @(posedge clk);
    #1 d = host_rd_data;
    release_bus();
  endtask : bus_read

  // The bus starts idle.
  initial begin
    host = '0;
    release_bus();
  end
endmodule : host_mcu_model

// >>> verification/complex_logic_array_output_macrocell_array_bench.sv
// Self-checking bench for the output cell array and its host bus.
// Assumes the host model and the checker are compiled before this file.
`timescale 1ns/1ps
module complex_logic_array_output_macrocell_array_bench;
  import complex_logic_array_omc_pkg::*;
  // ------
  // Signals
  // ------
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic edge_loading = 1'b0;
  logic ext_pin = 1'b0;
  logic [7:0] dir_a = 8'h00;
  host_bus_t host;
  logic [7:0] host_rd_data;
  logic host_rd_oe;
  cell_cfg_t [CELLS-1:0] cfg;
  cell_terms_t [CELLS-1:0] terms;
  port_pins_t pins;
  logic [7:0] fb_ab;
  logic [7:0] fb_bc;
  int num_errors = 0;
  int tests_run = 0;
  int seed = 61060;
  int g;
  logic [7:0] v, w, m, t, echo, got;
  logic [7:0] old [2];
  logic oe;

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  complex_logic_array_output_cell_array uut (.clk(clk), .srst(srst), .ce(1'b1),
    .host(host), .host_rd_data(host_rd_data), .host_rd_oe(host_rd_oe),
    .edge_loading(edge_loading), .cfg(cfg), .terms(terms),
    .external_flop_clock_pin(ext_pin), .dir_a(dir_a), .dir_b(8'h00),
    .dir_c(8'h00), .pins(pins), .group_ab_feedback(fb_ab),
    .group_bc_feedback(fb_bc));

  host_mcu_model host_mcu (.clk(clk), .host(host),
    .host_rd_data(host_rd_data), .host_rd_oe(host_rd_oe));

  // ------
  // Helpers
  // ------
  task automatic check8(input string name, input logic [7:0] e,
                        input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, e, s);
    end
  endtask : check8

  function automatic logic next_q(input flop_kind_t kd, input logic q,
                                  input logic s, input logic r);
    case (kd)
      FF_D: return s;
      FF_T: return q ^ s;
      FF_JK: return (s & ~q) | (~r & q);
      default: return s | (~r & q);
    endcase
  endfunction : next_q

  // Registered D cell using all native terms and borrowing none.
  function automatic cell_cfg_t plain(input pin_route_t r);
    cell_cfg_t c;
    c = '0;
    c.registered = 1'b1;
    c.route = r;
    c.use_native = 4'hF;
    return c;
  endfunction : plain

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // The whole run is a few hundred cycles; ten thousand means a hang.
  initial begin
    #100000;
    num_errors++;
    complete_run();
  end

  // ------
  // Tests
  // ------
  initial begin
    terms = '0;
    for (int i = 0; i < CELLS; i++) cfg[i] = plain(PIN_AUTO);
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    for (g = 0; g < 2; g++) begin
      host_mcu.bus_read(OFS_AB_MASK + 8'(g), got, oe);
      check8("mask reset", MASK_RESET, got);
      host_mcu.bus_read(OFS_AB_FLOPS + 8'(g), got, oe);
      check8("flop reset", FLOPS_RESET, got);
      check8("read enable", 8'h01, {7'h0, oe});
      old[g] = FLOPS_RESET;
    end
    host_mcu.bus_write(8'h24, 8'hA5, echo);
    host_mcu.bus_read(8'h24, got, oe);
    check8("unmapped enable", 8'h00, {7'h0, oe});
    $display("Reset test done");
    // Masked loads in level mode: open, closed, then random masks.
    for (int i = 0; i < 8; i++) begin
      g = i % 2;
      m = (i < 2) ? 8'h00 : (i < 4) ? 8'hFF : 8'($random(seed));
      v = 8'($random(seed));
      host_mcu.bus_write(OFS_AB_MASK + 8'(g), m, echo);
      host_mcu.bus_write(OFS_AB_FLOPS + 8'(g), v, echo);
      old[g] = (old[g] & m) | (v & ~m);
      host_mcu.bus_read(OFS_AB_FLOPS + 8'(g), got, oe);
      check8("masked load", old[g], got);
      check8("feedback", old[g], g ? fb_bc : fb_ab);
    end
    $display("Mask test done");
    // Edge mode loads nothing while the strobe is still low.
    edge_loading = 1'b1;
    host_mcu.bus_write(OFS_AB_MASK, 8'h00, echo);
    m = 8'($random(seed));
    v = 8'($random(seed));
    host_mcu.bus_write(OFS_BC_MASK, m, echo);
    host_mcu.bus_write(OFS_BC_FLOPS, v, echo);
    check8("edge echo", old[1], echo);
    old[1] = (old[1] & m) | (v & ~m);
    host_mcu.bus_read(OFS_BC_FLOPS, got, oe);
    check8("edge load", old[1], got);
    host_mcu.bus_write(OFS_BC_MASK, 8'h00, echo);
    edge_loading = 1'b0;
    $display("Edge test done");
    // Preset, then a host load against it, then the second clear term.
    for (int i = 0; i < GROUP; i++) terms[i].preset = 1'b1;
    repeat (2) @(posedge clk);
    #1 host_mcu.bus_read(OFS_AB_FLOPS, got, oe);
    check8("preset", 8'hFF, got);
    host_mcu.bus_write(OFS_AB_FLOPS, 8'h00, echo);
    check8("load over preset", 8'h00, echo);
    for (int i = 0; i < GROUP; i++) terms[i].clear[1] = 1'b1;
    repeat (2) @(posedge clk);
    #1 host_mcu.bus_read(OFS_AB_FLOPS, got, oe);
    check8("clear", 8'h00, got);
    terms = '0;
    // Every flop kind; AB clocks from a term, BC from the external pin.
    for (int kd = 0; kd < 4; kd++) begin
      old[0] = 8'($random(seed));
      old[1] = 8'($random(seed));
      host_mcu.bus_write(OFS_AB_FLOPS, old[0], echo);
      host_mcu.bus_write(OFS_BC_FLOPS, old[1], echo);
      for (int i = 0; i < CELLS; i++) begin
        cfg[i].kind = flop_kind_t'(kd);
        cfg[i].invert = 1'($random(seed));
        cfg[i].ext_clock = (i >= GROUP);
        terms[i].native[0] = 1'($random(seed));
        terms[i].k = 1'($random(seed));
        old[i / GROUP][i % GROUP] = next_q(flop_kind_t'(kd),
          old[i / GROUP][i % GROUP], terms[i].native[0] ^ cfg[i].invert,
          terms[i].k);
      end
      ext_pin = 1'b1;
      for (int i = 0; i < GROUP; i++) terms[i].clock = 1'b1;
      repeat (2) @(posedge clk);
      #1 ext_pin = 1'b0;
      terms = '0;
      for (g = 0; g < 2; g++) begin
        host_mcu.bus_read(OFS_AB_FLOPS + 8'(g), got, oe);
        check8("flop kind", old[g], got);
      end
    end
    $display("Flop kind test done");
    // Pin routing per mode, then the enable term, then a logic path.
    v = 8'($random(seed));
    w = 8'($random(seed));
    for (int i = 0; i < CELLS; i++) cfg[i] = plain(PIN_AUTO);
    host_mcu.bus_write(OFS_AB_FLOPS, v, echo);
    host_mcu.bus_write(OFS_BC_FLOPS, w, echo);
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < GROUP; i++) cfg[i] = plain(pin_route_t'(r));
      repeat (3) @(posedge clk);
      #1 check8("a enable", (r < 2) ? 8'hFF : 8'h00, pins.a_oe);
      check8("b enable", (r == 2) ? 8'hFF : 8'h00, pins.b_oe);
      if (r < 2) check8("a data", v, pins.a_out);
      if (r == 2) check8("b data", v, pins.b_out);
      check8("c data", w, pins.c_out);
      check8("c enable", 8'hFF, pins.c_oe);
      check8("node feedback", v, fb_ab);
    end
    t = 8'($random(seed));
    dir_a = 8'($random(seed));
    for (int i = 0; i < CELLS; i++) cfg[i] = plain(PIN_FIRST);
    for (int i = 0; i < GROUP; i++) cfg[i].oe_equation = 1'b1;
    for (int i = 0; i < GROUP; i++) terms[i].oe = t[i];
    repeat (3) @(posedge clk);
    #1 check8("enable term", t | dir_a, pins.a_oe);
    check8("bc on b", w, pins.b_out);
    check8("bc b enable", 8'hFF, pins.b_oe);
    for (int i = 0; i < GROUP; i++) begin
      cfg[i].registered = 1'b0;
      cfg[i].invert = 1'b1;
      cfg[i].oe_equation = 1'b0;
      terms[i].native[0] = t[i];
    end
    repeat (3) @(posedge clk);
    #1 check8("logic pin", ~t, pins.a_out);
    check8("logic feedback", ~t, fb_ab);
    $display("Pin test done");
    complete_run();
  end
endmodule : complex_logic_array_output_macrocell_array_bench

bind complex_logic_array_output_cell_array cell_array_checks chk (.clk(clk), .srst(srst),
  .ce(ce), .host(host), .host_rd_data(host_rd_data),
  .host_rd_oe(host_rd_oe), .edge_loading(edge_loading), .cfg(cfg),
  .terms(terms), .dir_a(dir_a), .pins(pins),
  .group_ab_feedback(group_ab_feedback));
